// ==== dv/line_partner.sv ====
`timescale 1ns/1ps
module line_partner #(
    parameter int HB = 10
) (
    input  wire logic aclk,
    input  wire logic txd,
    output logic      rxd
);
    logic [8:0] got_q[$];
    logic [8:0] sh;
    initial rxd = 1'b1;
    // Nine centre samples; stop or idle fill unused places
    initial begin
        forever begin
            @(negedge txd);
            repeat (HB) @(posedge aclk);
            for (int i = 0; i < 9; i++) begin
                repeat (2 * HB) @(posedge aclk);
                sh[i] = txd;
            end
            got_q.push_back(sh);
        end
    end
    // Start, data, parity, stop, then idle marks
    task automatic send(input logic [11:0] b);
        for (int i = 0; i < 12; i++) begin
            rxd <= b[i];
            repeat (2 * HB) @(posedge aclk);
        end
    endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
    logic        aclk          = 1'b0;
    logic        aresetn       = 1'b0;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata   = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb   = 4'hF;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_bready  = 1'b0;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready  = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, txd;
    logic        s_axi_arready, s_axi_rvalid, rxd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd_d;
    logic [8:0]  v;
    int          mismatches = 0;
    int          cmp_count  = 0;
    translating_uart #(.CLK_HZ(192000)) i_dut (.*);
    line_partner #(.HB(10)) i_partner (.aclk, .txd, .rxd);
    initial forever #5 aclk = ~aclk;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd_d = s_axi_rdata;
        resp = s_axi_rresp;
    endtask
    function automatic logic [8:0] exp9(logic [7:0] c, int n, int p);
        logic [8:0] e;
        e = 9'h1FF;
        for (int i = 0; i < n; i++) e[i] = c[i];
        if (p != 0) e[n] = ^(c & ~(8'hFF << n)) ^ (p == 1);
        return e;
    endfunction
    task automatic get_tx(input logic [8:0] e);
        for (int i = 0; i < 4000 && i_partner.got_q.size() == 0; i++)
            @(posedge aclk);
        v = i_partner.got_q.pop_front();
        cmp({23'h0, v}, {23'h0, e});
    endtask
    task automatic t_regs;
        rd(8'h00);
        cmp(rd_d, 32'h0000_003F);
        rd(8'h04);
        cmp(rd_d, 32'h0000_0010);
        rd(8'h1C);
        cmp({rd_d[29:0], resp}, 32'h0000_0002);
        wr(8'h1C, 32'h0000_0001);
        cmp({30'h0, resp}, 32'h0000_0002);
    endtask
    task automatic t_format;
        for (int l = 0; l < 4; l++) begin
            for (int p = 0; p < 3; p++) begin
                wr(8'h00, 32'h000F | l << 4 | p << 6 | p << 8);
                wr(8'h08, 32'h00D3 + l);
                get_tx(exp9(8'hD3 + l, l + 5, p));
                repeat (100) @(posedge aclk);
            end
        end
    endtask
    task automatic t_burst;
        wr(8'h00, 32'h0000_003F);
        wr(8'h08, 32'h0000_00A5);
        wr(8'h08, 32'h0000_003C);
        get_tx(exp9(8'hA5, 8, 0));
        get_tx(exp9(8'h3C, 8, 0));
    endtask
    task automatic t_rx;
        wr(8'h00, 32'h00AB_007F);
        i_partner.send({2'b11, 1'b1, 8'h5A, 1'b0});
        i_partner.send({2'b11, 1'b0, 8'h33, 1'b0});
        i_partner.send({2'b10, 1'b1, 8'h12, 1'b0});
        rd(8'h18);
        cmp(rd_d, 32'h0000_0003);
        rd(8'h0C);
        cmp(rd_d, 32'h0000_015A);
        rd(8'h0C);
        cmp(rd_d, 32'h0000_01AB);
        rd(8'h0C);
        cmp(rd_d, 32'h0000_01AB);
        rd(8'h04);
        cmp(rd_d & 32'h0000_0007, 32'h0000_0003);
        wr(8'h04, 32'h0000_0007);
        rd(8'h04);
        cmp(rd_d & 32'h0000_0017, 32'h0000_0010);
    endtask
    task automatic t_xlate;
        wr(8'h00, 32'h0000_103F);
        for (int i = 0; i < 256; i++) begin
            wr(8'h10, {16'h0, i[7:0], ~i[7:0]});
            wr(8'h14, {16'h0, i[7:0], ~i[7:0]});
        end
        rd(8'h04);
        cmp(rd_d & 32'h0000_00C0, 32'h0000_00C0);
        wr(8'h08, 32'h0000_000F);
        get_tx(exp9(8'hF0, 8, 0));
        i_partner.send({3'b111, 8'hFF, 1'b0});
        i_partner.send({3'b111, 8'h01, 1'b0});
        rd(8'h18);
        cmp(rd_d, 32'h0000_0001);
        rd(8'h0C);
        cmp(rd_d, 32'h0000_01FE);
    endtask
    task automatic t_ovr;
        for (int i = 0; i < 256; i++) i_partner.send({3'b111, 8'h02, 1'b0});
        rd(8'h18);
        cmp(rd_d, 32'h0000_00FF);
        rd(8'h04);
        cmp(rd_d & 32'h0000_0004, 32'h0000_0004);
    endtask
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_format;
        t_burst;
        t_rx;
        t_xlate;
        t_ovr;
        close_out;
    end
    initial begin
        #900_000;
        mismatches++;
        close_out;
    end
endmodule

// ==== dv/uart_props.sv ====
`timescale 1ns/1ps
module uart_props #(
    parameter int CLK_HZ = 100000000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic txd,
    input wire logic aw_tx
);
    // Every level holds at least one bit at rate 15
    localparam int LAST = CLK_HZ * 10 / 96000 - 9;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_write_ans: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready && !aw_tx |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_read_ans: assert property (s_axi_arvalid && s_axi_arready
        |-> ##[1:3] s_axi_rvalid) else $error("read response late");
    chk_b_once: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("write response twice");
    chk_r_once: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("read response twice");
    chk_aw_closed: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write open");
    chk_ar_closed: assert property (s_axi_arvalid && s_axi_arready
        |=> !s_axi_arready) else $error("read open");
    chk_start_len: assert property (
        $fell(txd) |-> !txd[*8] ##LAST !txd) else $error("low short");
    chk_stop_len: assert property (
        $rose(txd) |-> txd[*8] ##LAST txd) else $error("high short");
endmodule
bind translating_uart uart_props #(.CLK_HZ(CLK_HZ)) i_props (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .txd,
    .aw_tx (s_axi_awaddr == 8'h08)
);

// ==== hw/char_fifo.sv ====
`timescale 1ns/1ps
module char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic      [CW-1:0]    count
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PW-1:0]    wr_reg;
    logic [PW-1:0]    rd_reg;
    logic [CW-1:0]    cnt_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;
    wire [PW-1:0]     last = PW'(DEPTH - 1);

    assign in_ready  = cnt_reg != CW'(DEPTH);
    assign out_valid = cnt_reg != '0;
    assign out_data  = mem[rd_reg];
    assign count     = cnt_reg;

    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    // Oldest entry leaves first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == last) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == last) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
        end
    end
endmodule

// ==== hw/translating_uart.sv ====
`timescale 1ns/1ps
`include "uart_cfg.svh"
// What this block does
// - Idle transmit line stays at one
// - Frame opens with one-bit zero start
// - Low 5..8 data bits, LSB first
// - Optional odd or even parity bit
// - Stop of 1, 1.5 or 2 bits
// - Start needs fall held half bit
// - First sample 1.5 bits, then every bit
// - Unused upper received bits read zero unless substituted or translated
// - Parity mismatch sets parity error
// - Zero at stop sets framing error
// - 175 transmit, 255 receive characters buffered
// - Full transmit buffer stalls host transmit data writes
// - Receive buffer full sets overrun only
// - Bad characters replaced by substitute
// - Tables active once loaded after control
// - Transmit characters go through transmit table
// - Received characters go through receive table
// - Null deletion modes drop translated received zeros
// - Sixteen line rates, 50 to 9600
module translating_uart #(
    parameter int CLK_HZ   = `CLK_HZ,
    parameter int TX_DEPTH = `TX_DEPTH,
    parameter int RX_DEPTH = `RX_DEPTH
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             txd,
    input  wire logic        rxd
);
    localparam int TCW = $clog2(TX_DEPTH + 1);
    localparam int RCW = $clog2(RX_DEPTH + 1);

    // ------------------------------------------------------------
    // Half-bit length per rate; long counts scale with CLK_HZ
    // ------------------------------------------------------------
    function automatic logic [19:0] half_len(input logic [3:0] sel);
        int r;
        int n;
        case (sel)
            4'h0: r = `R0;
            4'h1: r = `R1;
            4'h2: r = `R2;
            4'h3: r = `R3;
            4'h4: r = `R4;
            4'h5: r = `R5;
            4'h6: r = `R6;
            4'h7: r = `R7;
            4'h8: r = `R8;
            4'h9: r = `R9;
            4'hA: r = `R10;
            4'hB: r = `R11;
            4'hC: r = `R12;
            4'hD: r = `R13;
            4'hE: r = `R14;
            default: r = `R15;
        endcase
        n = (CLK_HZ * 5) / r;
        return (n < 1) ? 20'h0_0001 : n[19:0];
    endfunction

    // ------------------------------------------------------------
    // Registers and control decode
    // ------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [2:0]  err_reg;
    logic        tx_ton_reg;
    logic        rx_ton_reg;
    logic [7:0]  tx_tbl [0:255];
    logic [7:0]  rx_tbl [0:255];

    wire [19:0] hl      = half_len(ctrl_reg[`CTRL_RATE_LSB +: 4]);
    wire [20:0] full_m1 = {hl, 1'b0} - 21'h00_0001;
    wire [3:0]  nbits   = 4'h5 + {2'h0, ctrl_reg[`CTRL_LEN_LSB +: 2]};
    wire [7:0]  cmask   = 8'hFF >> (4'h8 - nbits);
    wire [1:0]  par_sel = ctrl_reg[`CTRL_PAR_LSB +: 2];
    wire        par_on  = par_sel == uart_pkg::PAR_ODD
                       || par_sel == uart_pkg::PAR_EVEN;
    wire        par_odd = par_sel == uart_pkg::PAR_ODD;
    wire [1:0]  stop_sel = ctrl_reg[`CTRL_STOP_LSB +: 2];
    wire [2:0]  stop_m1 = (stop_sel == 2'h0) ? 3'h1 :
                          (stop_sel == 2'h1) ? 3'h2 : 3'h3;
    wire [3:0]  mode    = ctrl_reg[`CTRL_MODE_LSB +: 4];
    wire        null_del = mode == 4'h1 || mode == 4'h4;
    wire [7:0]  subst   = ctrl_reg[`CTRL_SUB_LSB +: 8];

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        tx_in_ready;
    wire aw_have = !s_axi_awready && !s_axi_bvalid;
    wire w_have  = !s_axi_wready && !s_axi_bvalid;
    wire wa_tx   = aw_addr_reg == `TXDATA_OFF;
    // Data write waits while transmit buffer has no room
    wire do_write = aw_have && w_have
                 && !(wa_tx && !tx_in_ready);
    wire wr_ctrl = do_write && aw_addr_reg == `CTRL_OFF;
    wire wr_stat = do_write && aw_addr_reg == `STAT_OFF;
    wire wr_tx   = do_write && wa_tx;
    wire wr_txt  = do_write && aw_addr_reg == `TXTBL_OFF;
    wire wr_rxt  = do_write && aw_addr_reg == `RXTBL_OFF;
    wire wr_ok   = wr_ctrl || wr_stat || wr_tx || wr_txt || wr_rxt
                || (do_write && aw_addr_reg == `RXDATA_OFF)
                || (do_write && aw_addr_reg == `RXCNT_OFF);
    wire [31:0] bmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                         {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wire [7:0]  tbl_idx = w_data_reg[`TBL_IDX_LSB +: 8];
    wire [7:0]  tx_char = w_data_reg[7:0];
    wire [7:0]  tx_xl = tx_ton_reg ? tx_tbl[tx_char] : tx_char;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_addr_reg   <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Tables have no reset; contents only matter once loaded
    always_ff @(posedge aclk) begin
        if (wr_txt) begin
            tx_tbl[tbl_idx] <= w_data_reg[7:0];
        end
        if (wr_rxt) begin
            rx_tbl[tbl_idx] <= w_data_reg[7:0];
        end
    end

    // Reloading control drops both tables until reloaded
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg   <= `CTRL_RST;
            tx_ton_reg <= 1'b0;
            rx_ton_reg <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_reg   <= (ctrl_reg & ~bmask) | (w_data_reg & bmask);
            tx_ton_reg <= 1'b0;
            rx_ton_reg <= 1'b0;
        end else begin
            if (wr_txt && tbl_idx == `TBL_LAST) begin
                tx_ton_reg <= 1'b1;
            end
            if (wr_rxt && tbl_idx == `TBL_LAST) begin
                rx_ton_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Buffers
    // ------------------------------------------------------------
    logic           tx_out_valid;
    logic [7:0]     tx_out_data;
    logic [TCW-1:0] tx_count;
    logic           tx_pop;
    logic           rx_push;
    logic [7:0]     rx_xl;
    logic           rx_in_ready;
    logic           rx_out_valid;
    logic [7:0]     rx_out_data;
    logic [RCW-1:0] rx_count;
    logic           rx_pop;

    char_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) tx_buf (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (wr_tx),
        .in_ready  (tx_in_ready),
        .in_data   (tx_xl),
        .out_valid (tx_out_valid),
        .out_ready (tx_pop),
        .out_data  (tx_out_data),
        .count     (tx_count)
    );

    char_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH)) rx_buf (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (rx_push),
        .in_ready  (rx_in_ready),
        .in_data   (rx_xl),
        .out_valid (rx_out_valid),
        .out_ready (rx_pop),
        .out_data  (rx_out_data),
        .count     (rx_count)
    );

    // ------------------------------------------------------------
    // Transmitter, stepped by half-bit ticks
    // ------------------------------------------------------------
    uart_pkg::tx_state_t tx_state;
    logic [19:0] tx_div;
    logic [7:0]  tx_sh;
    logic [3:0]  tx_left;
    logic [2:0]  tx_half;
    logic        tx_par;
    wire tx_tick  = tx_div >= hl - 20'h0_0001;
    wire tx_hdone = tx_half == 3'h0;
    wire tx_free  = tx_state == uart_pkg::TX_IDLE
                 || (tx_state == uart_pkg::TX_STOP && tx_hdone);
    wire [7:0] tx_m = tx_out_data & cmask;
    assign tx_pop = tx_tick && tx_free && tx_out_valid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_div <= 20'h0_0000;
        end else begin
            tx_div <= tx_tick ? 20'h0_0000 : tx_div + 20'h0_0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state <= uart_pkg::TX_IDLE;
            txd      <= 1'b1;
            tx_sh    <= 8'h00;
            tx_left  <= 4'h0;
            tx_half  <= 3'h0;
            tx_par   <= 1'b0;
        end else if (tx_pop) begin
            tx_state <= uart_pkg::TX_START;
            txd      <= 1'b0;
            tx_sh    <= tx_m;
            tx_par   <= ^tx_m ^ par_odd;
            tx_half  <= 3'h1;
        end else if (tx_tick) begin
            if (!tx_hdone) begin
                tx_half <= tx_half - 3'h1;
            end else begin
                case (tx_state)
                    uart_pkg::TX_START: begin
                        txd      <= tx_sh[0];
                        tx_sh    <= tx_sh >> 1;
                        tx_left  <= nbits - 4'h1;
                        tx_half  <= 3'h1;
                        tx_state <= uart_pkg::TX_DATA;
                    end
                    uart_pkg::TX_DATA: begin
                        tx_half <= 3'h1;
                        if (tx_left != 4'h0) begin
                            txd     <= tx_sh[0];
                            tx_sh   <= tx_sh >> 1;
                            tx_left <= tx_left - 4'h1;
                        end else if (par_on) begin
                            txd      <= tx_par;
                            tx_state <= uart_pkg::TX_PAR;
                        end else begin
                            txd      <= 1'b1;
                            tx_half  <= stop_m1;
                            tx_state <= uart_pkg::TX_STOP;
                        end
                    end
                    uart_pkg::TX_PAR: begin
                        txd      <= 1'b1;
                        tx_half  <= stop_m1;
                        tx_state <= uart_pkg::TX_STOP;
                    end
                    default: begin
                        txd      <= 1'b1;
                        tx_state <= uart_pkg::TX_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Receiver, timed from the start edge
    // ------------------------------------------------------------
    uart_pkg::rx_state_t rx_state;
    logic [20:0] rx_cnt;
    logic [7:0]  rx_sh;
    logic [3:0]  rx_left;
    logic        rx_prev;
    logic        rx_pe;
    wire rx_half = rx_cnt >= {1'b0, hl} - 21'h00_0001;
    wire rx_full = rx_cnt >= full_m1;
    wire [7:0] rx_char = rx_sh >> (4'h8 - nbits);
    wire rx_done = rx_state == uart_pkg::RX_STOP && rx_full;
    wire rx_bad  = rx_pe || !rxd;
    wire [7:0] rx_pre = rx_bad ? subst : rx_char;
    assign rx_xl = rx_ton_reg ? rx_tbl[rx_pre] : rx_pre;
    wire rx_keep = rx_done && !(null_del && rx_xl == 8'h00);
    assign rx_push = rx_keep && rx_in_ready;
    wire ovr_set = rx_keep && !rx_in_ready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_state <= uart_pkg::RX_IDLE;
            rx_cnt   <= 21'h00_0000;
            rx_sh    <= 8'h00;
            rx_left  <= 4'h0;
            rx_prev  <= 1'b1;
            rx_pe    <= 1'b0;
        end else begin
            rx_prev <= rxd;
            rx_cnt  <= rx_cnt + 21'h00_0001;
            case (rx_state)
                uart_pkg::RX_IDLE: begin
                    rx_cnt <= 21'h00_0000;
                    if (rx_prev && !rxd) begin
                        rx_state <= uart_pkg::RX_START;
                    end
                end
                uart_pkg::RX_START: begin
                    if (rx_half) begin
                        rx_cnt   <= 21'h00_0000;
                        rx_left  <= nbits;
                        rx_pe    <= 1'b0;
                        rx_state <= rxd ? uart_pkg::RX_IDLE
                                        : uart_pkg::RX_DATA;
                    end
                end
                uart_pkg::RX_DATA: begin
                    if (rx_full) begin
                        rx_cnt  <= 21'h00_0000;
                        rx_sh   <= {rxd, rx_sh[7:1]};
                        rx_left <= rx_left - 4'h1;
                        if (rx_left == 4'h1) begin
                            rx_state <= par_on ? uart_pkg::RX_PAR
                                               : uart_pkg::RX_STOP;
                        end
                    end
                end
                uart_pkg::RX_PAR: begin
                    if (rx_full) begin
                        rx_cnt   <= 21'h00_0000;
                        rx_pe    <= (^rx_char ^ rxd) != par_odd;
                        rx_state <= uart_pkg::RX_STOP;
                    end
                end
                uart_pkg::RX_STOP: begin
                    if (rx_full) begin
                        rx_state <= uart_pkg::RX_IDLE;
                    end
                end
                default: rx_state <= uart_pkg::RX_IDLE;
            endcase
        end
    end

    // Sticky errors: a new error beats a same-cycle clear
    wire [2:0] err_set = {ovr_set, rx_done && !rxd, rx_done && rx_pe};
    wire [2:0] err_clr = wr_stat ? (w_data_reg[2:0] & {3{w_strb_reg[0]}})
                                 : 3'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_reg <= 3'h0;
        end else begin
            err_reg <= (err_reg & ~err_clr) | err_set;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    logic [7:0] ar_addr_reg;
    wire do_read = !s_axi_arready && !s_axi_rvalid;
    wire [7:0] stat8 = {rx_ton_reg, tx_ton_reg,
                        tx_state != uart_pkg::TX_IDLE, !rx_out_valid,
                        !tx_in_ready, err_reg};
    wire rd_rx  = ar_addr_reg == `RXDATA_OFF;
    assign rx_pop = do_read && rd_rx && rx_out_valid;
    wire rd_ok = ar_addr_reg == `CTRL_OFF || ar_addr_reg == `STAT_OFF
              || ar_addr_reg == `TXDATA_OFF || rd_rx
              || ar_addr_reg == `TXTBL_OFF || ar_addr_reg == `RXTBL_OFF
              || ar_addr_reg == `RXCNT_OFF;
    wire [31:0] rd_data =
        (ar_addr_reg == `CTRL_OFF)  ? ctrl_reg :
        (ar_addr_reg == `STAT_OFF)  ? {24'h00_0000, stat8} :
        rd_rx ? {23'h00_0000, rx_out_valid, rx_out_data} :
        (ar_addr_reg == `RXCNT_OFF) ? 32'(rx_count) :
        32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
            ar_addr_reg   <= 8'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            ar_addr_reg   <= s_axi_araddr;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// ==== hw/uart_cfg.svh ====
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define CTRL_OFF    8'h00
`define STAT_OFF    8'h04
`define TXDATA_OFF  8'h08
`define RXDATA_OFF  8'h0C
`define TXTBL_OFF   8'h10
`define RXTBL_OFF   8'h14
`define RXCNT_OFF   8'h18
// ------------------------------------------------------------
// Control fields and reset value
// ------------------------------------------------------------
`define CTRL_RATE_LSB 0
`define CTRL_LEN_LSB  4
`define CTRL_PAR_LSB  6
`define CTRL_STOP_LSB 8
`define CTRL_MODE_LSB 12
`define CTRL_SUB_LSB  16
`define CTRL_RST      32'h0000_003F
// ------------------------------------------------------------
// Status fields, table entry fields
// ------------------------------------------------------------
`define ST_PERR   0
`define ST_FERR   1
`define ST_OVR    2
`define ST_TXFULL 3
`define ST_RXEMP  4
`define ST_TXBUSY 5
`define ST_TXTON  6
`define ST_RXTON  7
`define TBL_IDX_LSB 8
`define TBL_LAST    8'hFF
// ------------------------------------------------------------
// Timing: clock rate and line rates in tenths of bit/s
// ------------------------------------------------------------
`define CLK_HZ 100_000_000
`define R0  500
`define R1  750
`define R2  1000
`define R3  1100
`define R4  1345
`define R5  1500
`define R6  2000
`define R7  3000
`define R8  6000
`define R9  12000
`define R10 18000
`define R11 24000
`define R12 36000
`define R13 48000
`define R14 72000
`define R15 96000
`define TX_DEPTH 175
`define RX_DEPTH 255
`endif

// ==== hw/uart_pkg.sv ====
package uart_pkg;
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b010,
        TX_PAR   = 3'b011,
        TX_STOP  = 3'b100
    } tx_state_t;
    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_START = 3'b001,
        RX_DATA  = 3'b010,
        RX_PAR   = 3'b011,
        RX_STOP  = 3'b100
    } rx_state_t;
    typedef enum logic [1:0] {
        PAR_NONE = 2'b00,
        PAR_ODD  = 2'b01,
        PAR_EVEN = 2'b10
    } parity_t;
endpackage
